// >>> src/php_pkg.sv
`default_nettype none
package php_pkg;
   // Register map, one byte each on the plain register port
   localparam logic [7:0] PHP_ADDR_PORT0 = 8'h00;
   localparam logic [7:0] PHP_ADDR_PORT1 = 8'h01;
   localparam logic [7:0] PHP_ADDR_PORT2 = 8'h02;
   localparam logic [7:0] PHP_ADDR_CFG   = 8'h03;

   // Field positions in parallel_serial_config
   localparam int PHP_CFG_WIDTH_LO   = 0;
   localparam int PHP_CFG_WIDTH_HI   = 1;
   localparam int PHP_CFG_OUT_VALID  = 2;
   localparam int PHP_CFG_IN_FREE    = 3;
   localparam int PHP_CFG_OV_POL     = 4;
   localparam int PHP_CFG_IF_POL     = 5;
   localparam int PHP_CFG_ENABLE     = 6;

   // Writable bits of the config register
   localparam logic [7:0] PHP_CFG_RW_MASK = 8'h73;
   localparam logic [7:0] PHP_CFG_RESET   = 8'h00;

   // Width codes
   localparam logic [1:0] PHP_WIDTH_8  = 2'h0;
   localparam logic [1:0] PHP_WIDTH_16 = 2'h1;
   localparam logic [1:0] PHP_WIDTH_24 = 2'h2;

   // Handshake state after reset: latches empty, no output data
   localparam logic PHP_OUT_VALID_RESET = 1'b0;
   localparam logic PHP_IN_FREE_RESET   = 1'b1;

   // Read data source selector
   typedef enum logic [1:0] {
      PHP_RSRC_ZERO = 2'h0,
      PHP_RSRC_MEM  = 2'h1,
      PHP_RSRC_CFG  = 2'h3
   } php_rsrc_t;
endpackage : php_pkg
`default_nettype wire

// >>> src/php_latch_mem.sv
`timescale 1ns/1ps
`default_nettype none
// Input latches: all lanes written at once, one lane read out through a register
module php_latch_mem
   import php_pkg::*;
#(
   parameter int LANES = 3,
   parameter int W     = 8
) (
   // Clock and reset
   input  wire logic                 ref_clk_in,
   input  wire logic                 srst_in,
   // Write side
   input  wire logic                 wr_all_in,
   input  wire logic [LANES*W-1:0]   wdata_in,
   // Read side
   input  wire logic [1:0]           rsel_in,
   output var  logic [W-1:0]         q_out
);
   logic [LANES*W-1:0] store;

   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         store <= '0;
         q_out <= '0;
      end else begin
         if (wr_all_in) begin
            store <= wdata_in;
         end
         if (int'(rsel_in) < LANES) begin
            q_out <= store[rsel_in*W +: W];
         end else begin
            q_out <= '0;
         end
      end
   end
endmodule : php_latch_mem
`default_nettype wire

// >>> src/php_port.sv
`timescale 1ns/1ps
`default_nettype none
module php_port
   import php_pkg::*;
#(
   parameter int LANES = 3
) (
   // Clock and reset
   input  wire logic                 ref_clk_in,
   input  wire logic                 srst_in,
   // Register port
   input  wire logic [7:0]           reg_addr_in,
   input  wire logic [7:0]           reg_wdata_in,
   input  wire logic                 reg_wr_in,
   input  wire logic                 reg_rd_in,
   output var  logic [7:0]           reg_rdata_out,
   // External handshake inputs, active low
   input  wire logic                 input_strobe_n_in,
   input  wire logic                 output_enable_n_in,
   input  wire logic                 device_select_n_in,
   // Handshake outputs
   output var  logic                 in_free_pin_out,
   output var  logic                 in_free_pin_oe_out,
   output var  logic                 out_valid_pin_out,
   output var  logic                 out_valid_pin_oe_out,
   // Parallel data pins
   input  wire logic [LANES*8-1:0]   data_in,
   output var  logic [LANES*8-1:0]   data_out,
   output var  logic [LANES*8-1:0]   data_oe_out,
   // Combined port interrupt pulse
   output var  logic                 irq_out
);
   typedef struct packed {
      logic [LANES*8-1:0] out_data;
      logic [7:0]         cfg;
      logic               out_valid;
      logic               in_free;
      logic               rd_busy;
      logic               wr_busy;
      logic               irq;
      logic               ov_pin;
      logic               if_pin;
      logic               pins_oe;
      logic [LANES*8-1:0] data_oe;
      logic [7:0]         cfg_rdata;
      php_rsrc_t          rsrc;
   } php_state_t;

   php_state_t r;
   php_state_t next_r;
   logic [7:0] mem_q;

   // Lane enable mask from the width code; unknown code falls back to all lanes
   function automatic logic [LANES*8-1:0] php_lane_mask(input logic [1:0] width);
      logic [LANES*8-1:0] m;
      m = '0;
      for (int i = 0; i < LANES; i++) begin
         if ((width == PHP_WIDTH_8 && i < 1) || (width == PHP_WIDTH_16 && i < 2) ||
             (width != PHP_WIDTH_8 && width != PHP_WIDTH_16)) begin
            m[i*8 +: 8] = 8'hff;
         end
      end
      return m;
   endfunction : php_lane_mask

   logic enabled;
   logic oe_act;
   logic stb_act;
   logic fw_wr_p0;
   logic fw_rd_p0;
   logic [LANES*8-1:0] lane_mask;

   always_comb begin
      enabled   = r.cfg[PHP_CFG_ENABLE];
      oe_act    = enabled && !output_enable_n_in && !device_select_n_in;
      stb_act   = enabled && !input_strobe_n_in && !device_select_n_in;
      fw_wr_p0  = reg_wr_in && reg_addr_in == PHP_ADDR_PORT0;
      fw_rd_p0  = reg_rd_in && reg_addr_in == PHP_ADDR_PORT0;
      lane_mask = php_lane_mask(r.cfg[PHP_CFG_WIDTH_HI:PHP_CFG_WIDTH_LO]);
   end

   // Capture stays open while the strobe is low, so the last sample before release wins
   php_latch_mem #(
      .LANES (LANES),
      .W     (8)
   ) u_in_latch (
      .ref_clk_in (ref_clk_in),
      .srst_in    (srst_in),
      .wr_all_in  (stb_act),
      .wdata_in   (data_in),
      .rsel_in    (reg_addr_in[1:0]),
      .q_out      (mem_q)
   );

   always_comb begin
      next_r     = r;
      next_r.irq = 1'b0;

      // Firmware writes: output latches and config
      if (reg_wr_in) begin
         case (reg_addr_in)
            PHP_ADDR_PORT0: next_r.out_data[7:0] = reg_wdata_in;
            PHP_ADDR_PORT1: next_r.out_data[15:8] = reg_wdata_in;
            PHP_ADDR_PORT2: next_r.out_data[23:16] = reg_wdata_in;
            PHP_ADDR_CFG:   next_r.cfg = reg_wdata_in & PHP_CFG_RW_MASK;
            default:        next_r.cfg = r.cfg;
         endcase
      end

      // Output-valid: the firmware load wins over a read still in progress
      if (fw_wr_p0) begin
         next_r.out_valid = 1'b1;
      end else if (oe_act) begin
         next_r.out_valid = 1'b0;
      end

      // Input-free: a live strobe wins so a word arriving now is never marked free
      if (stb_act) begin
         next_r.in_free = 1'b0;
      end else if (fw_rd_p0) begin
         next_r.in_free = 1'b1;
      end

      // End of external read or write raises the interrupt
      next_r.rd_busy = oe_act;
      next_r.wr_busy = stb_act;
      if (r.rd_busy && !oe_act) begin
         next_r.irq = 1'b1;
      end
      if (r.wr_busy && !stb_act) begin
         next_r.irq = 1'b1;
      end

      // Pin levels follow the polarity bits
      next_r.ov_pin  = next_r.cfg[PHP_CFG_OV_POL] ? !next_r.out_valid : next_r.out_valid;
      next_r.if_pin  = next_r.cfg[PHP_CFG_IF_POL] ? !next_r.in_free : next_r.in_free;
      next_r.pins_oe = next_r.cfg[PHP_CFG_ENABLE];

      // Data drive: only enabled lanes, only during a selected read
      next_r.data_oe = oe_act ? lane_mask : '0;

      // Read path
      next_r.cfg_rdata = r.cfg;
      next_r.cfg_rdata[PHP_CFG_OUT_VALID] = !r.ov_pin;
      next_r.cfg_rdata[PHP_CFG_IN_FREE]   = !r.if_pin;
      next_r.rsrc = PHP_RSRC_ZERO;
      if (reg_rd_in) begin
         case (reg_addr_in)
            PHP_ADDR_PORT0: next_r.rsrc = PHP_RSRC_MEM;
            PHP_ADDR_PORT1: next_r.rsrc = PHP_RSRC_MEM;
            PHP_ADDR_PORT2: next_r.rsrc = PHP_RSRC_MEM;
            PHP_ADDR_CFG:   next_r.rsrc = PHP_RSRC_CFG;
            default:        next_r.rsrc = PHP_RSRC_ZERO;
         endcase
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         r           <= '0;
         r.cfg       <= PHP_CFG_RESET;
         r.out_valid <= PHP_OUT_VALID_RESET;
         r.in_free   <= PHP_IN_FREE_RESET;
         r.ov_pin    <= PHP_OUT_VALID_RESET;
         r.if_pin    <= PHP_IN_FREE_RESET;
         r.rsrc      <= PHP_RSRC_ZERO;
      end else begin
         r <= next_r;
      end
   end

   // Read data comes from one of two flops; unmapped and idle read as zero
   always_comb begin
      case (r.rsrc)
         PHP_RSRC_MEM: reg_rdata_out = mem_q;
         PHP_RSRC_CFG: reg_rdata_out = r.cfg_rdata;
         default:      reg_rdata_out = 8'h00;
      endcase
   end

   always_comb begin
      in_free_pin_out      = r.if_pin;
      in_free_pin_oe_out   = r.pins_oe;
      out_valid_pin_out    = r.ov_pin;
      out_valid_pin_oe_out = r.pins_oe;
      data_out             = r.out_data;
      data_oe_out          = r.data_oe;
      irq_out              = r.irq;
   end

   default clocking php_cb @(posedge ref_clk_in);
   endclocking
   default disable iff (srst_in);

   AST_OV_SET: assert property (
      fw_wr_p0 |=> r.out_valid ##0 (out_valid_pin_out == !r.cfg[PHP_CFG_OV_POL]))
      else $error("port0 write did not assert output-valid");

   AST_OV_CLR: assert property (
      (oe_act && !fw_wr_p0) |=> !r.out_valid)
      else $error("output enable did not clear output-valid");

   AST_IF_SET: assert property (
      (fw_rd_p0 && !stb_act) |=> r.in_free ##0 (in_free_pin_out == !r.cfg[PHP_CFG_IF_POL]))
      else $error("port0 read did not assert input-free");

   AST_IF_CLR: assert property (
      stb_act |=> !r.in_free)
      else $error("strobe did not clear input-free");

   AST_OV_POL: assert property (
      out_valid_pin_out == (r.cfg[PHP_CFG_OV_POL] ? !r.out_valid : r.out_valid))
      else $error("output-valid pin polarity wrong");

   AST_IF_POL: assert property (
      in_free_pin_out == (r.cfg[PHP_CFG_IF_POL] ? !r.in_free : r.in_free))
      else $error("input-free pin polarity wrong");

   AST_OV_STATUS: assert property (
      (reg_rd_in && reg_addr_in == PHP_ADDR_CFG) |=>
         reg_rdata_out[PHP_CFG_OUT_VALID] == !$past(out_valid_pin_out))
      else $error("output-valid status not inverse of pin");

   AST_IF_STATUS: assert property (
      (reg_rd_in && reg_addr_in == PHP_ADDR_CFG) |=>
         reg_rdata_out[PHP_CFG_IN_FREE] == !$past(in_free_pin_out))
      else $error("input-free status not inverse of pin");

   AST_IRQ_RD: assert property (
      (oe_act ##1 !oe_act) |=> irq_out ##1 !irq_out || $past(stb_act, 2))
      else $error("no interrupt after external read");

   AST_IRQ_WR: assert property (
      (stb_act ##1 !stb_act) |=> irq_out)
      else $error("no interrupt after external write");

   AST_DATA_DRIVE: assert property (
      oe_act |=> data_oe_out == $past(lane_mask))
      else $error("data lanes not driven during read");

   AST_GATE: assert property (
      (device_select_n_in || !enabled) |=> (data_oe_out == '0) && !r.wr_busy)
      else $error("unselected access had an effect");

   AST_PIN_OE: assert property (
      $rose(r.cfg[PHP_CFG_ENABLE]) |-> in_free_pin_oe_out && out_valid_pin_oe_out)
      else $error("handshake pins not driven when enabled");

   AST_CAPTURE: assert property (
      stb_act ##1 !stb_act ##1 (!stb_act && reg_rd_in && reg_addr_in == PHP_ADDR_PORT0)
         |=> reg_rdata_out == $past(data_in[7:0], 3))
      else $error("port0 latch did not capture strobe data");

   AST_WIDTH8: assert property (
      (oe_act && r.cfg[PHP_CFG_WIDTH_HI:PHP_CFG_WIDTH_LO] == PHP_WIDTH_8 && !reg_wr_in)
         |=> data_oe_out[LANES*8-1:8] == '0)
      else $error("8-bit width drove upper lanes");
endmodule : php_port
`default_nettype wire

// >>> test/php_ext_master.sv
`timescale 1ns/1ps
`default_nettype none
// External bus master; it drives pins_out at all times, and the bench bus mux gives lanes driven by the device priority
module php_ext_master (
   // Clock
   input  wire logic        clk_in,
   // Handshake view
   input  wire logic        in_free_pin_in,
   input  wire logic        out_valid_pin_in,
   input  wire logic        if_pol_in,
   input  wire logic        ov_pol_in,
   input  wire logic [23:0] pins_in,
   // Strobes and data, active low strobes
   output var  logic        stb_n_out,
   output var  logic        oe_n_out,
   output var  logic        cs_n_out,
   output var  logic [23:0] pins_out
);
   int n_late = 0;
   initial begin
      stb_n_out = 1'b1;
      oe_n_out = 1'b1;
      cs_n_out = 1'b1;
      pins_out = 24'h5a5a5a;
   end
   // Flag level is pin xor polarity; bounded so a dead device cannot hang us
   task automatic wait_flag(input logic rd);
      int n;
      n = 0;
      while ((rd ? out_valid_pin_in ^ ov_pol_in : in_free_pin_in ^ if_pol_in) !== 1'b1 && n < 50) begin
         @(posedge clk_in);
         n++;
      end
      if (n >= 50) n_late++;
   endtask : wait_flag
   task automatic ext_write(input logic [23:0] d, input logic sel);
      wait_flag(1'b0);
      @(posedge clk_in);
      pins_out <= d;
      stb_n_out <= 1'b0;
      cs_n_out <= ~sel;
      @(posedge clk_in);
      stb_n_out <= 1'b1;
      cs_n_out <= 1'b1;
      // Released data no longer shows the old word
      pins_out <= ~d;
   endtask : ext_write
   task automatic ext_read(output logic [23:0] q);
      wait_flag(1'b1);
      @(posedge clk_in);
      oe_n_out <= 1'b0;
      cs_n_out <= 1'b0;
      repeat (2) @(posedge clk_in);
      q = pins_in;
      oe_n_out <= 1'b1;
      cs_n_out <= 1'b1;
   endtask : ext_read
endmodule : php_ext_master
`default_nettype wire

// >>> test/php_port_tb.sv
`timescale 1ns/1ps
`default_nettype none
module php_port_tb
   import php_pkg::*;
;
   logic        ref_clk_in, srst_in, wr_stb, rd_stb, stb_n, oe_n, cs_n;
   logic        if_pin, if_oe, ov_pin, ov_oe, irq, ov, free;
   logic [7:0]  reg_addr, reg_wdata, rdata, cfg;
   logic [23:0] d_out, d_oe, x_out, bus;
   logic [31:0] seed;
   int          n_fail = 0, checks = 0, irq_n = 0;
   assign bus = (d_out & d_oe) | (x_out & ~d_oe);
   php_port php_port_i (.ref_clk_in(ref_clk_in), .srst_in(srst_in), .reg_addr_in(reg_addr),
      .reg_wdata_in(reg_wdata), .reg_wr_in(wr_stb), .reg_rd_in(rd_stb), .reg_rdata_out(rdata),
      .input_strobe_n_in(stb_n), .output_enable_n_in(oe_n), .device_select_n_in(cs_n),
      .in_free_pin_out(if_pin), .in_free_pin_oe_out(if_oe), .out_valid_pin_out(ov_pin),
      .out_valid_pin_oe_out(ov_oe), .data_in(bus), .data_out(d_out), .data_oe_out(d_oe),
      .irq_out(irq));
   php_ext_master php_ext_master_i (.clk_in(ref_clk_in), .in_free_pin_in(if_pin),
      .out_valid_pin_in(ov_pin), .if_pol_in(cfg[5]), .ov_pol_in(cfg[4]), .pins_in(bus),
      .stb_n_out(stb_n), .oe_n_out(oe_n), .cs_n_out(cs_n), .pins_out(x_out));
   always @(posedge ref_clk_in) if (irq === 1'b1) irq_n <= irq_n + 1;
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs
   task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
      checks++;
      if (g !== e) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk_in);
      reg_addr <= a;
      reg_wdata <= d;
      wr_stb <= 1'b1;
      @(posedge ref_clk_in);
      wr_stb <= 1'b0;
   endtask : reg_wr
   task automatic reg_rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge ref_clk_in);
      reg_addr <= a;
      rd_stb <= 1'b1;
      @(posedge ref_clk_in);
      rd_stb <= 1'b0;
      @(posedge ref_clk_in);
      chk("reg read", {16'h0, e}, {16'h0, rdata});
   endtask : reg_rd
   // Status bits read as the inverse of their pins
   function automatic logic [7:0] exp_cfg();
      logic [7:0] e;
      e = cfg & PHP_CFG_RW_MASK;
      e[PHP_CFG_OUT_VALID] = cfg[PHP_CFG_OV_POL] ? ov : ~ov;
      e[PHP_CFG_IN_FREE] = cfg[PHP_CFG_IF_POL] ? free : ~free;
      return e;
   endfunction : exp_cfg
   task automatic conclude();
      $display("checks=%0d n_fail=%0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : conclude
   initial begin
      ref_clk_in = 1'b0;
      forever #12.5 ref_clk_in = ~ref_clk_in;
   end
   initial begin
      #500000;
      n_fail++;
      conclude();
   end
   initial begin : main
      logic [23:0] q, m, d;
      int k, n0;
      srst_in = 1'b1;
      reg_addr = 8'h0;
      reg_wdata = 8'h0;
      wr_stb = 1'b0;
      rd_stb = 1'b0;
      seed = 32'he1e34efb;
      cfg = PHP_CFG_RESET;
      ov = PHP_OUT_VALID_RESET;
      free = PHP_IN_FREE_RESET;
      repeat (3) @(posedge ref_clk_in);
      srst_in <= 1'b0;
      reg_rd(PHP_ADDR_CFG, exp_cfg());
      reg_rd(8'h07, 8'h00);
      cfg = 8'hff;
      reg_wr(PHP_ADDR_CFG, cfg);
      reg_rd(PHP_ADDR_CFG, exp_cfg());
      chk("pin drive", 24'h3, {22'h0, if_oe, ov_oe});
      php_ext_master_i.ext_write(24'h123456, 1'b0);
      repeat (3) @(posedge ref_clk_in);
      chk("irq gated", 24'h0, 24'(irq_n));
      reg_rd(PHP_ADDR_CFG, exp_cfg());
      for (k = 0; k < 4; k++) begin
         // Every width code, every polarity pair
         cfg = 8'h40 | 8'(k << 4) | 8'(k);
         reg_wr(PHP_ADDR_CFG, cfg);
         m = (k == 0) ? 24'hff : (k == 1) ? 24'hffff : 24'hffffff;
         d = 24'(xs());
         reg_wr(PHP_ADDR_PORT2, d[23:16]);
         reg_wr(PHP_ADDR_PORT1, d[15:8]);
         reg_wr(PHP_ADDR_PORT0, d[7:0]);
         ov = 1'b1;
         reg_rd(PHP_ADDR_CFG, exp_cfg());
         chk("valid pin", {23'h0, ov ^ cfg[4]}, {23'h0, ov_pin});
         n0 = irq_n;
         php_ext_master_i.ext_read(q);
         ov = 1'b0;
         // Lanes left undriven must show the master's own levels
         chk("read data", (d & m) | (x_out & ~m), q);
         repeat (3) @(posedge ref_clk_in);
         chk("irq read", 24'(n0 + 1), 24'(irq_n));
         chk("drive off", 24'h0, d_oe);
         d = 24'(xs());
         php_ext_master_i.ext_write(d, 1'b1);
         free = 1'b0;
         repeat (3) @(posedge ref_clk_in);
         chk("irq write", 24'(n0 + 2), 24'(irq_n));
         chk("free pin", {23'h0, free ^ cfg[5]}, {23'h0, if_pin});
         reg_rd(PHP_ADDR_CFG, exp_cfg());
         if (k > 0) reg_rd(PHP_ADDR_PORT1, d[15:8]);
         if (k > 1) reg_rd(PHP_ADDR_PORT2, d[23:16]);
         reg_rd(PHP_ADDR_PORT0, d[7:0]);
         free = 1'b1;
         reg_rd(PHP_ADDR_CFG, exp_cfg());
      end
      // Firmware empties the latch right behind the strobe
      d = 24'(xs());
      php_ext_master_i.ext_write(d, 1'b1);
      reg_rd(PHP_ADDR_PORT0, d[7:0]);
      chk("irq write", 24'(n0 + 3), 24'(irq_n));
      chk("free pin", {23'h0, free ^ cfg[5]}, {23'h0, if_pin});
      chk("flag waits", 24'h0, 24'(php_ext_master_i.n_late));
      conclude();
   end
endmodule : php_port_tb
`default_nettype wire
